// ==== include/refresh_timer_pkg.sv ====
// package: register map, field layout, keys and limits of the refresh timer
package refresh_timer_pkg;
  // =========================================================
  // register byte offsets on the wishbone slave
  localparam logic [4:0] OFS_CTRL     = 5'h00;
  localparam logic [4:0] OFS_COUNT    = 5'h04;
  localparam logic [4:0] OFS_CONST    = 5'h08;
  localparam logic [4:0] OFS_EVENTS   = 5'h0c;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
  localparam logic [4:0] OFS_IRQ_CLR  = 5'h14;
  localparam logic [4:0] OFS_IRQ_EN   = 5'h18;
  localparam logic [4:0] OFS_MEM_CTRL = 5'h1c;
  // =========================================================
  // timer_ctrl_status field positions
  localparam int unsigned BIT_CMF  = 7;
  localparam int unsigned BIT_COMPARE_IRQ_ENABLE = 6;
  localparam int unsigned BIT_CKS  = 3;
  localparam int unsigned BIT_OVF  = 2;
  localparam int unsigned BIT_OVERFLOW_IRQ_ENABLE = 1;
  localparam int unsigned BIT_LIMIT_SELECT = 0;
  // memory_control_reg and interrupt status fields
  localparam int unsigned BIT_REFRESH_ENABLE = 0;
  localparam int unsigned BIT_CBR  = 1;
  localparam int unsigned IRQ_CMP  = 0;
  localparam int unsigned IRQ_OVF  = 1;
  // =========================================================
  // write protection and access size
  localparam logic [7:0] KEY_BYTE  = 8'ha5;
  localparam logic [5:0] KEY_EVENT = 6'h29;
  localparam logic [3:0] SEL_HALF  = 4'h3;
  // =========================================================
  // widths, reset values and limits
  localparam int unsigned CNT_W   = 8;
  localparam int unsigned EVT_W   = 10;
  localparam logic [7:0]  CNT_RST = 8'h00;
  localparam logic [9:0]  EVT_RST = 10'h000;
  localparam logic [10:0] LIMIT_FULL = 11'h400;
  localparam logic [10:0] LIMIT_HALF = 11'h200;
  // =========================================================
  // prescaler: log2 of the divider per clock_select code
  localparam int unsigned PRESC_W = 12;
  localparam int unsigned DIV_LOG2 [8] = '{0, 2, 4, 6, 8, 10, 11, 12};
  localparam logic [2:0]  CKS_STOP = 3'h0;
endpackage : refresh_timer_pkg

// ==== include/refresh_timer_if.sv ====
// interfaces: prescaler link and register write gate link
`timescale 1ns/1ps
interface prescale_if;
  logic [2:0] clock_select;
  logic       hold;
  logic       tick;
  modport ctrl (output clock_select, hold, input tick);
  modport div  (input clock_select, hold, output tick);
endinterface : prescale_if

interface write_gate_if;
  logic        clk_sys;
  logic        rstn;
  logic [4:0]  adr;
  logic [31:0] dat;
  logic [3:0]  sel;
  logic        strobe;
  logic        wr_ctrl;
  logic        wr_count;
  logic        wr_const;
  logic        wr_events;
  logic        wr_clr;
  logic        wr_en;
  logic        wr_mem;
  modport bus  (output clk_sys, rstn, adr, dat, sel, strobe,
                input wr_ctrl, wr_count, wr_const, wr_events,
                wr_clr, wr_en, wr_mem);
  modport gate (input clk_sys, rstn, adr, dat, sel, strobe,
                output wr_ctrl, wr_count, wr_const, wr_events,
                wr_clr, wr_en, wr_mem);
endinterface : write_gate_if

// ==== rtl/bus_clock_prescaler.sv ====
// bus clock divider that makes the interval counter's count ticks
`timescale 1ns/1ps
module bus_clock_prescaler
  import refresh_timer_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  prescale_if.div  pre
);
  logic [PRESC_W-1:0] phase;
  wire  [PRESC_W-1:0] mask;

  // =========================================================
  // divider: all low bits set once per 2**n cycles
  assign mask = PRESC_W'((32'h1 << DIV_LOG2[pre.clock_select]) - 32'h1);
  assign pre.tick = (pre.clock_select != CKS_STOP) && !pre.hold
                    && ((phase & mask) == mask);

  // phase stops in standby so the count holds
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      phase <= '0;
    else if (!pre.hold)
      phase <= phase + PRESC_W'(1);
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_stop_select: assert property (
    pre.clock_select == CKS_STOP |-> !pre.tick)
    else $error("tick while clock input disabled");
  a_div4_spacing: assert property (
    pre.tick && pre.clock_select == 3'h1 && $stable(pre.clock_select)
    |=> !pre.tick [*3])
    else $error("divide by 4 tick too early");
endmodule : bus_clock_prescaler

// ==== rtl/register_write_gate.sv ====
// write gate: checks size and key before a timer register may change; interrupt and memory control need only byte lane 0
`timescale 1ns/1ps
module register_write_gate
  import refresh_timer_pkg::*;
(
  write_gate_if.gate g
);
  wire size_ok;
  wire key_byte_ok;
  wire key_event_ok;
  wire own_ok;

  // =========================================================
  // only a low halfword access passes a keyed register; keys sit above the data
  assign size_ok      = (g.sel == SEL_HALF);
  assign key_byte_ok  = (g.dat[15:8] == KEY_BYTE);
  assign key_event_ok = (g.dat[15:10] == KEY_EVENT);
  assign own_ok       = g.strobe && g.sel[0];

  // keyed registers: a bad key or size discards the write
  assign g.wr_ctrl   = g.strobe && size_ok && key_byte_ok
                       && g.adr[4:2] == OFS_CTRL[4:2];
  assign g.wr_count  = g.strobe && size_ok && key_byte_ok
                       && g.adr[4:2] == OFS_COUNT[4:2];
  assign g.wr_const  = g.strobe && size_ok && key_byte_ok
                       && g.adr[4:2] == OFS_CONST[4:2];
  assign g.wr_events = g.strobe && size_ok && key_event_ok
                       && g.adr[4:2] == OFS_EVENTS[4:2];
  // unkeyed interrupt and memory control registers
  assign g.wr_clr = own_ok && g.adr[4:2] == OFS_IRQ_CLR[4:2];
  assign g.wr_en  = own_ok && g.adr[4:2] == OFS_IRQ_EN[4:2];
  assign g.wr_mem = own_ok && g.adr[4:2] == OFS_MEM_CTRL[4:2];

  // checks on the bus clock carried in the gate link
  a_key_guard: assert property (
    @(posedge g.clk_sys) disable iff (!g.rstn)
    (g.wr_ctrl || g.wr_count || g.wr_const)
    |-> (g.dat[15:8] == KEY_BYTE && g.sel == SEL_HALF))
    else $error("keyed write passed without key or halfword");
  a_event_key: assert property (
    @(posedge g.clk_sys) disable iff (!g.rstn)
    g.wr_events |-> (g.dat[15:10] == KEY_EVENT && g.sel == SEL_HALF))
    else $error("event counter write passed without key");
endmodule : register_write_gate

// ==== rtl/dram_refresh_timer.sv ====
// refresh interval timer with wishbone registers and interrupt output
//
// Contract
// - interval counter is 8 bits, counts once per selected clock tick
// - match of counter and constant sets compare flag, clears counter
// - low 8 bits compared continuously, independent of register access
// - reset clears counter; manual reset keeps counting; standby holds it
// - refresh enabled in CBR mode starts a refresh when compare flag rises
// - reset clears interval constant; manual reset and standby keep it
// - refresh event counter is 10 bits, plus one per match
// - event counter past selected limit sets overflow flag, clears counter
// - reset clears event counter; manual reset and standby keep it
// - the four timer registers accept only 16-bit writes
// - counter, control and constant writes carry key in upper byte
// - event counter writes carry six-bit key above ten data bits
// - reads are 16-bit; undefined bit positions read zero
// - clock select: 000 stops, others divide by 4 up to 4096
// - limit select 0 gives limit 1024, 1 gives 512
// - writing 1 keeps compare flag; 0 or finished CBR refresh clears
// - interrupt when a flag is set together with its enable
`timescale 1ns/1ps
module dram_refresh_timer
  import refresh_timer_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        standby,
  input  wire logic        refresh_done,
  output logic             refresh_req,
  output logic             irq
);
  // =========================================================
  // state
  logic [CNT_W-1:0] interval_counter;
  logic [CNT_W-1:0] interval_constant;
  logic [EVT_W-1:0] refresh_event_counter;
  logic             compare_match_flag;
  logic             compare_irq_enable;
  logic [2:0]       clock_select;
  logic             overflow_flag;
  logic             overflow_irq_enable;
  logic             limit_select;
  logic [1:0]       memory_control_reg;
  logic [1:0]       irq_status;
  logic [1:0]       irq_enable;

  prescale_if   pre ();
  write_gate_if wg ();

  wire        req;
  wire        commit;
  wire        tick;
  wire        match;
  wire        match_event;
  wire [10:0] limit;
  wire        limit_hit;
  wire        ovf_event;
  wire        cbr_on;
  wire        cbr_clear;
  wire        refresh_start;
  wire        cmf_wr_clear;
  wire        ovf_wr_clear;
  wire [1:0]  irq_events;
  wire        next_irq;
  wire [15:0] ctrl_word;
  logic [31:0] next_rdata;
  logic [7:0]  next_counter;
  logic [9:0]  next_events;

  // =========================================================
  // sub blocks: divider and write gate
  assign pre.clock_select = clock_select;
  assign pre.hold         = standby;
  assign tick             = pre.tick;

  bus_clock_prescaler u_prescaler (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .pre     (pre.div)
  );

  assign wg.clk_sys = clk_sys;
  assign wg.rstn    = rstn;
  assign wg.adr    = wb_adr_i;
  assign wg.dat    = wb_dat_i;
  assign wg.sel    = wb_sel_i;
  assign wg.strobe = commit;

  register_write_gate u_write_gate (
    .g (wg.gate)
  );

  // =========================================================
  // wishbone slave: ack one cycle after request, write at ack edge
  assign req    = wb_cyc_i && wb_stb_i;
  assign commit = req && wb_we_i && wb_ack_o;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      if (req && !wb_ack_o)
        wb_dat_o <= next_rdata;
    end
  end

  // read mux; every undefined bit reads zero
  assign ctrl_word = {8'h00, compare_match_flag, compare_irq_enable,
                      clock_select, overflow_flag,
                      overflow_irq_enable, limit_select};

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (wb_adr_i[4:2])
      OFS_CTRL[4:2]:     next_rdata = {16'h0000, ctrl_word};
      OFS_COUNT[4:2]:    next_rdata = {24'h000000, interval_counter};
      OFS_CONST[4:2]:    next_rdata = {24'h000000, interval_constant};
      OFS_EVENTS[4:2]:   next_rdata = {22'h0, refresh_event_counter};
      OFS_IRQ_STAT[4:2]: next_rdata = {30'h0, irq_status};
      OFS_IRQ_EN[4:2]:   next_rdata = {30'h0, irq_enable};
      OFS_MEM_CTRL[4:2]: next_rdata = {30'h0, memory_control_reg};
      default:           next_rdata = 32'h0000_0000;  // clear reg, write only
    endcase
  end

  // =========================================================
  // compare: low 8 bits against the constant, acted on at count ticks
  assign match       = (interval_counter == interval_constant);
  assign match_event = tick && match;

  // event counter limit and overflow
  assign limit     = limit_select ? LIMIT_HALF : LIMIT_FULL;
  assign limit_hit = ({1'b0, refresh_event_counter} + 11'h001) == limit;
  assign ovf_event = match_event && limit_hit;

  // refresh request and its completion
  assign cbr_on = memory_control_reg[BIT_REFRESH_ENABLE]
                  && memory_control_reg[BIT_CBR];
  assign refresh_start = match_event && !compare_match_flag
                         && cbr_on;
  assign cbr_clear     = refresh_done && cbr_on;

  // flags clear when software writes 0 into them; compare flag also on finished CBR refresh
  assign cmf_wr_clear = wg.wr_ctrl && !wb_dat_i[BIT_CMF];
  assign ovf_wr_clear = wg.wr_ctrl && !wb_dat_i[BIT_OVF];

  assign irq_events = {ovf_event, match_event};
  assign next_irq   = (compare_match_flag && compare_irq_enable)
                      || (overflow_flag && overflow_irq_enable)
                      || (|(irq_status & irq_enable));

  // next counter values; a software write wins over counting
  always_comb begin
    next_counter = interval_counter;
    if (wg.wr_count)
      next_counter = wb_dat_i[7:0];
    else if (match_event)
      next_counter = CNT_RST;
    else if (tick)
      next_counter = interval_counter + 8'h01;
  end

  always_comb begin
    next_events = refresh_event_counter;
    if (wg.wr_events)
      next_events = wb_dat_i[9:0];
    else if (ovf_event)
      next_events = EVT_RST;
    else if (match_event)
      next_events = refresh_event_counter + 10'h001;
  end

  // =========================================================
  // counters; power-on reset clears them, otherwise they take the next values
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      interval_counter      <= CNT_RST;
      refresh_event_counter <= EVT_RST;
    end else begin
      interval_counter      <= next_counter;
      refresh_event_counter <= next_events;
    end
  end

  // interval constant
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      interval_constant <= CNT_RST;
    else if (wg.wr_const)
      interval_constant <= wb_dat_i[7:0];
  end

  // control/status fields; a setting event wins over a clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      compare_match_flag  <= 1'b0;
      overflow_flag       <= 1'b0;
      compare_irq_enable  <= 1'b0;
      clock_select        <= CKS_STOP;
      overflow_irq_enable <= 1'b0;
      limit_select        <= 1'b0;
    end else begin
      compare_match_flag <= match_event || (compare_match_flag
                            && !cmf_wr_clear && !cbr_clear);
      overflow_flag      <= ovf_event
                            || (overflow_flag && !ovf_wr_clear);
      if (wg.wr_ctrl) begin
        compare_irq_enable  <= wb_dat_i[BIT_COMPARE_IRQ_ENABLE];
        clock_select        <= wb_dat_i[BIT_CKS +: 3];
        overflow_irq_enable <= wb_dat_i[BIT_OVERFLOW_IRQ_ENABLE];
        limit_select        <= wb_dat_i[BIT_LIMIT_SELECT];
      end
    end
  end

  // memory control, interrupt status, enable and outputs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      memory_control_reg <= 2'h0;
      irq_status         <= 2'h0;
      irq_enable         <= 2'h0;
      refresh_req        <= 1'b0;
      irq                <= 1'b0;
    end else begin
      if (wg.wr_mem)
        memory_control_reg <= wb_dat_i[1:0];
      if (wg.wr_en)
        irq_enable <= wb_dat_i[1:0];
      irq_status  <= irq_events
                     | (irq_status & ~({2{wg.wr_clr}} & wb_dat_i[1:0]));
      refresh_req <= refresh_start;
      irq         <= next_irq;
    end
  end

  // =========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_flag_rises;
    match_event && !compare_match_flag && cbr_on;
  endsequence
  sequence s_refresh_pulse;
    refresh_req ##1 !refresh_req;
  endsequence

  a_match_clears: assert property (
    match_event && !wg.wr_count && !wg.wr_ctrl
    |=> interval_counter == CNT_RST && compare_match_flag)
    else $error("match did not clear counter and set flag");
  a_count_step: assert property (
    tick && !match && !wg.wr_count
    |=> interval_counter == $past(interval_counter) + 8'h01)
    else $error("interval counter missed a tick");
  a_standby_hold: assert property (
    standby && !wg.wr_count |=> $stable(interval_counter))
    else $error("interval counter moved in standby");
  a_event_step: assert property (
    match_event && !limit_hit && !wg.wr_events
    |=> refresh_event_counter == $past(refresh_event_counter) + 10'h001)
    else $error("event counter did not advance on match");
  a_overflow_set: assert property (
    ovf_event && !wg.wr_events
    |=> overflow_flag && refresh_event_counter == EVT_RST)
    else $error("overflow not flagged at limit");
  a_refresh_start: assert property (
    s_flag_rises |=> s_refresh_pulse)
    else $error("refresh request not a single pulse");
  a_flag_keep: assert property (
    compare_match_flag && wg.wr_ctrl && wb_dat_i[BIT_CMF]
    && !cbr_clear |=> compare_match_flag)
    else $error("writing 1 cleared the compare flag");
  a_irq_level: assert property (
    compare_match_flag && compare_irq_enable |=> irq)
    else $error("enabled compare flag gave no interrupt");
  a_ack_single: assert property (
    req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule : dram_refresh_timer

// ==== verification/tb_top.sv ====
// testbench: wishbone-driven self-checking bench of the refresh timer
`timescale 1ns/1ps
module tb_top;
  import refresh_timer_pkg::*;
  // ==========================================================
  // signals, notes queue and counters
  typedef struct packed {logic [31:0] exp; logic [31:0] msk;} note_t;
  logic        clk_sys, rstn, standby, refresh_done;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        refresh_req, irq;
  logic [4:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, got, seed;
  note_t       notes[$];
  note_t       mon_n;
  int          bad_count, num_checks, cycles, rq_cnt, r0, c, ls;
  int          divs [8] = '{0, 4, 16, 64, 256, 1024, 2048, 4096};

  dram_refresh_timer dut (.clk_sys(clk_sys), .rstn(rstn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .standby(standby),
    .refresh_done(refresh_done), .refresh_req(refresh_req), .irq(irq));

  // ==========================================================
  // compare, verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  // ==========================================================
  // wishbone classic master cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [4:0] adr,
    input logic [31:0] dat, input logic [3:0] sel, output logic [31:0] d);
    int i;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 50);
    d = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (i >= 50) check(32'h1, 32'h0);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d,
    input logic [3:0] s);
    logic [31:0] g;
    bus(1'b1, a, d, s, g);
  endtask : wr

  task automatic kw(input logic [4:0] a, input logic [7:0] v);
    wr(a, {16'h0, KEY_BYTE, v}, SEL_HALF);
  endtask : kw

  task automatic ew(input logic [5:0] k, input logic [9:0] v);
    wr(OFS_EVENTS, {16'h0, k, v}, SEL_HALF);
  endtask : ew

  task automatic rd(input logic [4:0] a, input logic [31:0] e,
    input logic [31:0] m);
    notes.push_back('{e, m});
    bus(1'b0, a, 32'h0, 4'hf, got);
  endtask : rd

  // poll refresh_req (0) or irq (1) on falling edges, bounded
  task automatic wait_hi(input int which);
    int i;
    for (i = 0; i < 300 && (which ? irq : refresh_req) !== 1'b1; i++)
      @(negedge clk_sys);
  endtask : wait_hi

  // ==========================================================
  // clock, cycle ceiling, refresh pulse count, read data monitor
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (refresh_req === 1'b1) rq_cnt++;
    if (cycles == 60000) begin
      bad_count++;
      test_done();
    end
  end

  always @(posedge clk_sys) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (notes.size() == 0) check(32'h1, 32'h0);
      else begin
        mon_n = notes.pop_front();
        check(wb_dat_o & mon_n.msk, mon_n.exp & mon_n.msk);
      end
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    {rstn, standby, refresh_done, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    seed = $urandom(32'h5fb9142a);
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    // reset values and unused bits
    rd(OFS_CTRL, 32'h0, '1);
    rd(OFS_COUNT, 32'h0, '1);
    rd(OFS_CONST, 32'h0, '1);
    rd(OFS_EVENTS, 32'h0, '1);
    rd(OFS_IRQ_CLR, 32'h0, '1);
    $display("test reset done");
    // key, size and write-one protection
    seed = $urandom;
    wr(OFS_CONST, {16'h0, KEY_BYTE ^ 8'h01, seed[7:0]}, SEL_HALF);
    rd(OFS_CONST, 32'h0, '1);
    wr(OFS_CONST, {16'h0, KEY_BYTE, seed[7:0]}, 4'h1);
    rd(OFS_CONST, 32'h0, '1);
    kw(OFS_CONST, seed[7:0]);
    rd(OFS_CONST, {24'h0, seed[7:0]}, '1);
    kw(OFS_COUNT, seed[15:8]);
    rd(OFS_COUNT, {24'h0, seed[15:8]}, '1);
    ew(KEY_EVENT ^ 6'h01, seed[25:16]);
    rd(OFS_EVENTS, 32'h0, '1);
    ew(KEY_EVENT, seed[25:16]);
    rd(OFS_EVENTS, {22'h0, seed[25:16]}, '1);
    kw(OFS_CTRL, 8'h80);
    rd(OFS_CTRL, 32'h0, '1);
    $display("test protect done");
    // clock select codes, then standby freeze
    kw(OFS_CONST, 8'hff);
    for (c = 0; c < 9; c++) begin
      standby <= (c == 8);
      kw(OFS_COUNT, 8'h00);
      kw(OFS_CTRL, (c == 8) ? 8'h08 : 8'(c << 3));
      repeat ((c == 0 || c == 8) ? 64 : 2 * divs[c]) @(posedge clk_sys);
      kw(OFS_CTRL, 8'h00);
      rd(OFS_COUNT, 32'h0, 32'h0);
      if (c == 0 || c == 8) check(got, 32'h0);
      else check(32'(got >= 1 && got <= 3), 32'h1);
    end
    standby <= 1'b0;
    $display("test clock select done");
    // compare match, refresh start, flags and interrupts
    kw(OFS_CONST, 8'h03);
    kw(OFS_COUNT, 8'h00);
    ew(KEY_EVENT, 10'h000);
    wr(OFS_MEM_CTRL, 32'h3, 4'h1);
    rd(OFS_MEM_CTRL, 32'h3, '1);
    kw(OFS_CTRL, 8'h48);
    wait_hi(0);
    check({31'h0, refresh_req}, 32'h1);
    kw(OFS_CTRL, 8'hc0);
    @(negedge clk_sys);
    check({31'h0, irq}, 32'h1);
    rd(OFS_EVENTS, 32'h1, '1);
    rd(OFS_CTRL, 32'hc0, '1);
    rd(OFS_COUNT, 32'h0, 32'h0);
    check(32'(got <= 1), 32'h1);
    rd(OFS_IRQ_STAT, 32'h1, 32'h3);
    kw(OFS_CTRL, 8'h40);
    rd(OFS_CTRL, 32'h40, '1);
    check({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_EN, 32'h1, 4'h1);
    repeat (2) @(negedge clk_sys);
    check({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_CLR, 32'h1, 4'h1);
    rd(OFS_IRQ_STAT, 32'h0, 32'h3);
    check({31'h0, irq}, 32'h0);
    kw(OFS_CTRL, 8'h08);
    wait_hi(0);
    kw(OFS_CTRL, 8'h80);
    @(posedge clk_sys);
    refresh_done <= 1'b1;
    @(posedge clk_sys);
    refresh_done <= 1'b0;
    rd(OFS_CTRL, 32'h0, '1);
    wr(OFS_IRQ_EN, 32'h0, 4'h1);
    wr(OFS_IRQ_CLR, 32'h3, 4'h1);
    $display("test compare done");
    // overflow at both limits, refresh disabled
    wr(OFS_MEM_CTRL, 32'h0, 4'h1);
    r0 = rq_cnt;
    kw(OFS_CONST, 8'h00);
    for (ls = 0; ls < 2; ls++) begin
      ew(KEY_EVENT, ls ? 10'd510 : 10'd1022);
      kw(OFS_CTRL, 8'h0a | 8'(ls));
      wait_hi(1);
      check({31'h0, irq}, 32'h1);
      kw(OFS_CTRL, 8'h86 | 8'(ls));
      rd(OFS_IRQ_STAT, 32'h2, 32'h2);
      wr(OFS_IRQ_CLR, 32'h2, 4'h1);
      rd(OFS_CTRL, 32'h86 | ls, '1);
      rd(OFS_EVENTS, 32'h0, 32'h0);
      check(32'(got <= 3), 32'h1);
      kw(OFS_CTRL, 8'(ls));
      repeat (2) @(negedge clk_sys);
      check({31'h0, irq}, 32'h0);
    end
    check(32'(rq_cnt - r0), 32'h0);
    $display("test overflow done");
    test_done();
  end
endmodule : tb_top
